// ---- rtl/rrds_top.v ----
// Result data selector: builds the cyclic send area from the requested data id.
// Assumes the controller side of the exchange area is clocked by sys_clk logic;
// image-processing results arrive as level inputs held stable across a result.
//
// What this block does
// RULE1 - For id 09 the first user byte carries the selected program number.
// RULE2 - For id 09 with the lock set, byte two is 00H on active override, 01H otherwise.
// RULE3 - Ids 81..8F pick content: bit0 string, bit1 absolute quality, bit2 classes, bit3 position.
// RULE4 - With no id supplied, processing runs but nothing goes into the send area.
// RULE5 - Id 09 is answered without any processing trigger edge.
// RULE6 - Properties pack as position, absolute quality, classes, then the string.
// RULE7 - Position is X, Y, roll and viewing angle, each signed 16 bits.
// RULE8 - The viewing angle is emitted only at the most demanding quality level.
// RULE9 - Absolute quality values are 32-bit floats, byte order set by the swap input.
// RULE10 - Classes are five characters: contrast, growth, non-uniformity, ecc, overall.
// RULE11 - Quality content is only delivered when the verification job is configured.
// RULE12 - A packet carries at most 27 user bytes.
// RULE13 - The controller reads the whole 32-byte area without an image update between.
// RULE14 - Send byte 1 sequence, bytes 2..3 net length, byte 4 id, bytes 5..31 user data.
// RULE15 - The controller writes the request id into receive byte 4, last good packet in byte 1.
// RULE16 - Matching acknowledge in receive byte 1 loads the next packet and bumps the sequence.
// RULE17 - Ids other than 09 and 81..8F are ignored and move no data.
`timescale 1ns/1ps
`include "rrds_defines.vh"
module rrds_top (
  input  wire         sys_clk,
  input  wire         rst,
  // Receive area bytes from the controller
  input  wire [7:0]   rx_ack_seq,
  input  wire [7:0]   rx_data_id,
  // Control byte bits
  input  wire         control_lock,
  input  wire         processing_trigger,
  // Reader state
  input  wire [3:0]   prog_number,
  input  wire         override_active,
  input  wire         quality_max_level,
  input  wire         verify_job_on,
  input  wire         swap_bytes,
  input  wire         result_valid,
  input  wire [15:0]  pos_x,
  input  wire [15:0]  pos_y,
  input  wire [15:0]  pos_roll,
  input  wire [15:0]  pos_view,
  input  wire [127:0] qual_abs,
  input  wire [39:0]  qual_cls,
  // Result string byte stream
  input  wire [7:0]   str_len,
  output reg  [7:0]   str_index,
  input  wire [7:0]   str_byte,
  // Send area, flattened byte 0 in the low bits
  output reg  [255:0] tx_area,
  output wire         packet_loaded
);
  // ==========================================================
  // Request decode
  localparam S_IDLE = 3'd0;
  localparam S_PACK = 3'd1;
  localparam S_LOAD = 3'd2;
  localparam S_WAIT = 3'd3;
  localparam S_DONE = 3'd4;

  localparam P_POS = 2'd0;
  localparam P_ABS = 2'd1;
  localparam P_CLS = 2'd2;
  localparam P_STR = 2'd3;

  // Bit span of the user bytes in the flattened send area
  localparam USER_LO = `RRDS_B_USER0 * 8;
  localparam AREA_HI = `RRDS_AREA_BYTES * 8 - 1;

  reg  [2:0]   state_reg;
  reg  [1:0]   part_reg;
  reg  [7:0]   idx_reg;
  reg  [7:0]   id_reg;
  reg  [3:0]   sel_reg;
  reg  [15:0]  total_reg;
  reg  [15:0]  left_reg;
  reg  [7:0]   seq_reg;
  reg  [4:0]   fill_reg;
  reg          trg_meta_reg;
  reg          trg_sync_reg;
  reg          trg_prev_reg;
  reg          load_pulse_reg;
  reg  [7:0]   pk_byte;
  reg          pk_valid;
  reg          pk_last;
  wire         trg_edge;
  wire         id_is_prog;
  wire         id_is_sel;
  wire [3:0]   id_bits;
  wire [3:0]   eff_sel;
  wire [7:0]   fifo_q;
  wire         fifo_valid;
  wire         fifo_in_ready;
  wire         fifo_rd;
  wire         fifo_flush;
  wire [7:0]   pos_len;
  wire [15:0]  calc_len;
  wire         id_changed;

  // ==========================================================
  // Byte pickers
  // Picks byte k of a 32-bit float, honouring the configured swap order
  function [7:0] float_byte;
    input [31:0] f;
    input [1:0]  k;
    input        sw;
    reg   [1:0]  j;
    begin
      j = sw ? k : (2'd3 - k);
      float_byte = f[j*8 +: 8];
    end
  endfunction

  // Byte k of a 16-bit value, high byte first
  function [7:0] int_byte;
    input [15:0] v;
    input        k;
    begin
      int_byte = k ? v[7:0] : v[15:8];
    end
  endfunction

  // Any change of the requested id abandons the transfer in flight
  assign id_changed = (rx_data_id != id_reg);
  assign id_is_prog = (rx_data_id == `RRDS_ID_PROG);
  assign id_is_sel  = (rx_data_id >= `RRDS_ID_SEL_MIN) &&
                      (rx_data_id <= `RRDS_ID_SEL_MAX);      // [RULE17]
  assign id_bits    = rx_data_id[3:0];                         // [RULE3]
  // Quality parts dropped when the verification job is off
  assign eff_sel    = verify_job_on ? id_bits :
                      {id_bits[`RRDS_SEL_POS], 2'b00, id_bits[`RRDS_SEL_STR]}; // [RULE11]
  assign pos_len    = quality_max_level ? `RRDS_POS_BYTES : `RRDS_POS_NOVIEW; // [RULE8]
  assign calc_len   = (eff_sel[`RRDS_SEL_POS] ? {8'h00, pos_len} : 16'h0000) +
                      (eff_sel[`RRDS_SEL_ABS] ? `RRDS_ABS_BYTES : 16'h0000) +
                      (eff_sel[`RRDS_SEL_CLS] ? `RRDS_CLS_BYTES : 16'h0000) +
                      (eff_sel[`RRDS_SEL_STR] ? {8'h00, str_len} : 16'h0000);

  // ==========================================================
  // Trigger synchroniser and edge
  // Trigger pin is asynchronous: two flops before the edge detector
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trg_meta_reg <= 1'b0;
      trg_sync_reg <= 1'b0;
      trg_prev_reg <= 1'b0;
    end else begin
      trg_meta_reg <= processing_trigger;
      trg_sync_reg <= trg_meta_reg;
      trg_prev_reg <= trg_sync_reg;
    end
  end
  assign trg_edge = trg_sync_reg & ~trg_prev_reg;

  // ==========================================================
  // Content packer, one byte per cycle into the FIFO
  always @* begin
    pk_byte   = 8'h00;
    pk_valid  = 1'b0;
    pk_last   = 1'b0;
    str_index = idx_reg;
    if (state_reg == S_PACK || state_reg == S_LOAD || state_reg == S_WAIT) begin
      if (id_reg == `RRDS_ID_PROG) begin
        pk_valid = (part_reg == P_POS);
        pk_last  = (idx_reg == 8'd1);
        // Lock report is driven whatever the lock bit; meaningless when clear
        if (idx_reg == 8'd0)
          pk_byte = {4'h0, prog_number};                         // [RULE1]
        else
          pk_byte = override_active ? `RRDS_OVR_ACTIVE : `RRDS_OVR_INACTIVE; // [RULE2]
      end else begin
        case (part_reg)                                          // [RULE6]
          P_POS: begin
            pk_valid = sel_reg[`RRDS_SEL_POS];
            case (idx_reg[2:1])                                  // [RULE7]
              2'd0:    pk_byte = int_byte(pos_x, idx_reg[0]);
              2'd1:    pk_byte = int_byte(pos_y, idx_reg[0]);
              2'd2:    pk_byte = int_byte(pos_roll, idx_reg[0]);
              default: pk_byte = int_byte(pos_view, idx_reg[0]);
            endcase
            pk_last = (idx_reg == pos_len - 8'd1);
          end
          P_ABS: begin
            pk_valid = sel_reg[`RRDS_SEL_ABS];
            pk_byte  = float_byte(qual_abs[idx_reg[3:2]*32 +: 32],
                                  idx_reg[1:0], swap_bytes);     // [RULE9]
            pk_last  = (idx_reg == `RRDS_ABS_BYTES - 1);
          end
          P_CLS: begin
            pk_valid = sel_reg[`RRDS_SEL_CLS];
            pk_byte  = qual_cls[idx_reg[2:0]*8 +: 8];            // [RULE10]
            pk_last  = (idx_reg == `RRDS_CLS_BYTES - 1);
          end
          default: begin
            // String restarts after its end; loader stops on left_reg, IDLE flushes
            pk_valid = sel_reg[`RRDS_SEL_STR] && (str_len != 8'h00);
            pk_byte  = str_byte;
            pk_last  = (idx_reg == str_len - 8'd1);
          end
        endcase
      end
    end
  end

  wire pk_push = pk_valid & fifo_in_ready;
  wire pk_skip = ~pk_valid;

  // ==========================================================
  // Byte FIFO
  // Lets the packer prefetch up to 16 bytes of the next packet while the controller acks
  rrds_fifo #(
    .W  (`RRDS_FIFO_W),
    .D  (`RRDS_FIFO_D),
    .AW (`RRDS_FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .flush     (fifo_flush),
    .in_data   (pk_byte),
    .in_valid  (pk_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_q),
    .out_valid (fifo_valid),
    .out_ready (state_reg == S_LOAD)
  );

  assign fifo_rd    = fifo_valid && (state_reg == S_LOAD);
  assign fifo_flush = (state_reg == S_IDLE);

  // ==========================================================
  // Sequencer
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg      <= S_IDLE;
      part_reg       <= P_POS;
      idx_reg        <= 8'h00;
      id_reg         <= `RRDS_ID_NONE;
      sel_reg        <= 4'h0;
      total_reg      <= 16'h0000;
      left_reg       <= 16'h0000;
      seq_reg        <= 8'h00;
      fill_reg       <= 5'd0;
      load_pulse_reg <= 1'b0;
      tx_area        <= 256'h0;
    end else begin
      load_pulse_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          part_reg <= P_POS;
          idx_reg  <= 8'h00;
          fill_reg <= 5'd0;
          // Prog id needs no trigger; others wait for a fresh result
          if (id_is_prog) begin                                  // [RULE5]
            id_reg    <= rx_data_id;
            sel_reg   <= 4'h0;
            total_reg <= 16'd2;
            left_reg  <= 16'd2;
            seq_reg   <= 8'h00;
            state_reg <= S_PACK;
          end else if (id_is_sel && trg_edge && result_valid) begin
            id_reg    <= rx_data_id;
            sel_reg   <= eff_sel;
            total_reg <= calc_len;
            left_reg  <= calc_len;
            seq_reg   <= 8'h00;
            state_reg <= S_PACK;
          end                                                    // [RULE4] [RULE17]
        end
        S_PACK, S_LOAD, S_WAIT: begin
          // Packer advances on push or skip of an empty part
          if (pk_push || pk_skip) begin
            if (pk_last || pk_skip) begin
              idx_reg <= 8'h00;
              if (part_reg == P_STR || id_reg == `RRDS_ID_PROG)
                part_reg <= P_STR;
              else
                part_reg <= part_reg + 2'd1;
            end else begin
              idx_reg <= idx_reg + 8'd1;
            end
          end
          if (state_reg == S_PACK) begin
            if (left_reg == 16'h0000) begin
              tx_area   <= 256'h0;
              state_reg <= S_DONE;
            end else begin
              tx_area   <= 256'h0;
              fill_reg  <= 5'd0;
              state_reg <= S_LOAD;
            end
          end else if (state_reg == S_LOAD) begin
            if (id_changed) begin
              // Withdrawn request: never publish a packet under a stale id
              state_reg <= S_IDLE;
            end
            if (fifo_rd && !id_changed) begin
              tx_area[(`RRDS_B_USER0 + fill_reg)*8 +: 8] <= fifo_q; // [RULE14]
              fill_reg <= fill_reg + 5'd1;
              left_reg <= left_reg - 16'd1;
            end
            // Packet closes at 27 bytes or when data runs out
            if ((fifo_rd && !id_changed && (fill_reg == `RRDS_USER_MAX - 1 ||
                             left_reg == 16'd1))) begin          // [RULE12]
              tx_area[`RRDS_B_SEQ*8 +: 8]    <= seq_reg + 8'd1;   // [RULE16]
              tx_area[`RRDS_B_LEN_HI*8 +: 8] <= total_reg[15:8]; // [RULE14]
              tx_area[`RRDS_B_LEN_LO*8 +: 8] <= total_reg[7:0];
              tx_area[`RRDS_B_ID*8 +: 8]     <= id_reg;
              seq_reg        <= seq_reg + 8'd1;
              load_pulse_reg <= 1'b1;
              state_reg      <= S_WAIT;
            end
          end else begin
            // Next packet only after the controller echoes our number
            if (id_changed) begin
              state_reg <= S_IDLE;
            end else if (rx_ack_seq == seq_reg) begin            // [RULE16]
              if (left_reg == 16'h0000) begin
                state_reg <= S_DONE;
              end else begin
                // Stale user bytes must not show in a short final packet
                tx_area[AREA_HI:USER_LO] <= {(AREA_HI - USER_LO + 1){1'b0}};
                fill_reg  <= 5'd0;
                state_reg <= S_LOAD;
              end
            end
          end
        end
        S_DONE: begin
          // Hold last packet until the request changes or a new trigger; a held id 09 goes back to IDLE at once and reloads
          if (id_changed || trg_edge || id_is_prog) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign packet_loaded = load_pulse_reg;
endmodule // rrds_top

// ---- rtl/rrds_defines.vh ----
// Constants for the reader result data selector.
// Assumes inclusion by bare name from the design files.
`ifndef RRDS_DEFINES_VH
`define RRDS_DEFINES_VH
// ==========================================================
// Data identifiers
`define RRDS_ID_NONE      8'h00
`define RRDS_ID_PROG      8'h09
`define RRDS_ID_SEL_BASE  8'h80
`define RRDS_ID_SEL_MIN   8'h81
`define RRDS_ID_SEL_MAX   8'h8f
`define RRDS_SEL_STR      0
`define RRDS_SEL_ABS      1
`define RRDS_SEL_CLS      2
`define RRDS_SEL_POS      3
// ==========================================================
// Lock report values
`define RRDS_OVR_ACTIVE   8'h00
`define RRDS_OVR_INACTIVE 8'h01
// ==========================================================
// Send area layout
`define RRDS_AREA_BYTES   32
`define RRDS_B_SEQ        1
`define RRDS_B_LEN_HI     2
`define RRDS_B_LEN_LO     3
`define RRDS_B_ID         4
`define RRDS_B_USER0      5
`define RRDS_USER_MAX     27
`define RRDS_POS_BYTES    8'd8
`define RRDS_POS_NOVIEW   8'd6
`define RRDS_ABS_BYTES    16'd16
`define RRDS_CLS_BYTES    16'd5
`define RRDS_STR_MAX      255
// ==========================================================
// Buffer shape
`define RRDS_FIFO_W       8
`define RRDS_FIFO_D       16
`define RRDS_FIFO_AW      4
`endif

// ---- rtl/rrds_fifo.v ----
// Byte FIFO between the content packer and the packet loader.
// Assumes one clock; flip-flop storage addressed by index.
`timescale 1ns/1ps
module rrds_fifo #(
  parameter W  = 8,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire          sys_clk,
  input  wire          rst,
  input  wire          flush,
  input  wire [W-1:0]  in_data,
  input  wire          in_valid,
  output wire          in_ready,
  output reg  [W-1:0]  out_data,
  output wire          out_valid,
  input  wire          out_ready
);
  reg [W-1:0]  mem_reg [0:D-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0]   cnt_reg;
  wire         wr_en;
  wire         rd_en;
  integer      i;

  assign in_ready  = (cnt_reg != D);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign wr_en     = in_valid & in_ready;
  assign rd_en     = out_valid & out_ready;

  always @* begin
    out_data = mem_reg[rp_reg];
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      for (i = 0; i < D; i = i + 1)
        mem_reg[i] <= {W{1'b0}};
    end else if (flush) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (wr_en) begin
        mem_reg[wp_reg] <= in_data;
        wp_reg          <= wp_reg + 1'b1;
      end
      if (rd_en)
        rp_reg <= rp_reg + 1'b1;
      if (wr_en && !rd_en)
        cnt_reg <= cnt_reg + 1'b1;
      else if (rd_en && !wr_en)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule // rrds_fifo

// ---- verification/rrds_ctrl_model.sv ----
// Controller-side partner: acknowledges each loaded packet of the send area.
// Assumes the bench drives the requested id and that all logic runs on sys_clk.
`timescale 1ns/1ps
module rrds_ctrl_model (
  input  wire         sys_clk,
  input  wire         rst,
  input  wire         slow,
  input  wire [7:0]   rx_data_id,
  input  wire [255:0] tx_area,
  input  wire         packet_loaded,
  output reg  [7:0]   rx_ack_seq
);
  reg [255:0] area_reg;
  reg [7:0]   id_reg;
  integer     wait_cnt;
  // ==========================================================
  // Acknowledge engine
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_ack_seq <= 8'h00;
      area_reg <= 256'h0;
      id_reg <= 8'h00;
      wait_cnt <= -1;
    end else begin
      id_reg <= rx_data_id;
      if (rx_data_id != id_reg) begin
        // Stale ack must not advance a fresh request
        rx_ack_seq <= 8'h00;
        wait_cnt <= -1;
      end else if (packet_loaded) begin
        area_reg <= tx_area;
        wait_cnt <= slow ? 20 : 1;
      end else if (wait_cnt == 0) begin
        rx_ack_seq <= area_reg[15:8];
        wait_cnt <= -1;
      end else if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule // rrds_ctrl_model

// ---- verification/rrds_top_assertions.sv ----
// Concurrent checks on the send area of rrds_top.
// Assumes binding to rrds_top; one clock, reset rst active high.
`timescale 1ns/1ps
module rrds_top_assertions (
  input wire         sys_clk,
  input wire         rst,
  input wire [7:0]   rx_data_id,
  input wire [3:0]   prog_number,
  input wire         override_active,
  input wire [255:0] tx_area,
  input wire         packet_loaded
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire        is_prog = tx_area[39:32] == 8'h09;
  wire        id_ok   = rx_data_id == 8'h09 || (rx_data_id >= 8'h81 && rx_data_id <= 8'h8f);
  wire [15:0] net_len = {tx_area[23:16], tx_area[31:24]};
  // ==========================================================
  // Properties
  prog_byte_a: assert property (packet_loaded && is_prog |-> tx_area[47:40] == {4'h0, prog_number})
    else $error("program byte wrong");
  lock_byte_a: assert property (packet_loaded && is_prog |->
    tx_area[55:48] == (override_active ? 8'h00 : 8'h01)) else $error("lock byte wrong");
  prog_len_a: assert property (packet_loaded && is_prog |-> net_len == 16'h0002)
    else $error("program length wrong");
  echo_id_a: assert property (packet_loaded && $stable(rx_data_id) |-> tx_area[39:32] == rx_data_id)
    else $error("id byte wrong");
  seq_valid_a: assert property (packet_loaded |-> tx_area[15:8] != 8'h00)
    else $error("sequence zero");
  no_id_quiet_a: assert property ((!id_ok) [*8] |-> !packet_loaded)
    else $error("load without valid id");
  prog_answer_a: assert property ($rose(rx_data_id == 8'h09) |-> ##[1:30] packet_loaded)
    else $error("program id not answered");
  load_pulse_a: assert property (packet_loaded |=> !packet_loaded)
    else $error("load pulse too long");
  tail_zero_a: assert property (packet_loaded && tx_area[15:8] == 8'h01 && net_len <= 16'd27 |->
    (tx_area >> (8 * (5 + net_len))) == 256'h0) else $error("tail bytes not zero");
  cover property (packet_loaded && is_prog);
  cover property (packet_loaded && tx_area[39:32] == 8'h8f);
  cover property (packet_loaded && tx_area[15:8] == 8'h02);
endmodule // rrds_top_assertions
bind rrds_top rrds_top_assertions rrds_top_assertions_inst (.sys_clk, .rst, .rx_data_id,
  .prog_number, .override_active, .tx_area, .packet_loaded);

// ---- verification/rrds_top_test.sv ----
// Self-checking bench for rrds_top and its byte FIFO.
// Assumes rrds_ctrl_model acknowledges packets; string bytes come from a fixed pattern.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module rrds_top_test;
  reg          sys_clk, rst, control_lock, processing_trigger, override_active;
  reg          quality_max_level, verify_job_on, swap_bytes, result_valid, ack_slow;
  reg  [7:0]   rx_data_id, str_len;
  reg  [3:0]   prog_number;
  reg  [63:0]  pos;
  reg  [127:0] qual_abs;
  reg  [39:0]  qual_cls;
  wire [7:0]   rx_ack_seq, str_index, str_byte;
  wire [255:0] tx_area;
  wire         packet_loaded;
  reg  [7:0]   eb [0:127];
  integer      en, bad_count, n_checks, i, npk, extra;
  assign str_byte = str_index + 8'h61;
  rrds_top rrds_top_inst (.sys_clk(sys_clk), .rst(rst), .rx_ack_seq(rx_ack_seq),
    .rx_data_id(rx_data_id), .control_lock(control_lock), .processing_trigger(processing_trigger),
    .prog_number(prog_number), .override_active(override_active), .quality_max_level(quality_max_level),
    .verify_job_on(verify_job_on), .swap_bytes(swap_bytes), .result_valid(result_valid),
    .pos_x(pos[63:48]), .pos_y(pos[47:32]), .pos_roll(pos[31:16]), .pos_view(pos[15:0]),
    .qual_abs(qual_abs), .qual_cls(qual_cls), .str_len(str_len), .str_index(str_index),
    .str_byte(str_byte), .tx_area(tx_area), .packet_loaded(packet_loaded));
  rrds_ctrl_model rrds_ctrl_model_inst (.sys_clk(sys_clk), .rst(rst), .slow(ack_slow),
    .rx_data_id(rx_data_id), .tx_area(tx_area), .packet_loaded(packet_loaded), .rx_ack_seq(rx_ack_seq));
  // ==========================================================
  // Helpers
  task automatic stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task automatic put(input [7:0] b);
    begin
      eb[en] = b;
      en = en + 1;
    end
  endtask
  task automatic build(input [7:0] id);
    integer q, b;
    reg [31:0] f;
    begin
      en = 0;
      if (id[3]) for (q = 0; q < (quality_max_level ? 8 : 6); q++) put(pos[63 - 8 * q -: 8]);
      if (id[1] && verify_job_on) for (q = 0; q < 4; q++) begin
        f = qual_abs[32 * q +: 32];
        for (b = 0; b < 4; b++) put(swap_bytes ? f[8 * b +: 8] : f[31 - 8 * b -: 8]);
      end
      if (id[2] && verify_job_on) for (q = 0; q < 5; q++) put(qual_cls[8 * q +: 8]);
      if (id[0]) for (q = 0; q < str_len; q++) put(q[7:0] + 8'h61);
    end
  endtask
  task automatic wait_load;
    integer t;
    begin
      t = 0;
      while (packet_loaded !== 1'b1 && t < 400) begin
        @(negedge sys_clk);
        t++;
      end
      `CHK("loaded", 1'b1, packet_loaded)
      @(negedge sys_clk);
    end
  endtask
  task automatic go_idle;
    begin
      @(posedge sys_clk);
      rx_data_id <= 8'h00;
      repeat (10) @(posedge sys_clk);
    end
  endtask
  task automatic pulse_trigger;
    begin
      @(posedge sys_clk);
      processing_trigger <= 1'b1;
      repeat (4) @(posedge sys_clk);
      processing_trigger <= 1'b0;
    end
  endtask
  // ==========================================================
  // Scenarios
  // Long string through the top: the FIFO fills up while a slow ack holds the loader
  task automatic t_fifo;
    begin
      str_len <= 8'd40;
      ack_slow <= 1'b1;
      run_sel(8'h81);
      `CHK("fifo_fill", 2, npk)
      `CHK("fifo_word", 8'h88, tx_area[8 * 17 +: 8])
      `CHK("fifo_drain", 0, extra)
    end
  endtask
  task automatic t_prog(input ovr);
    begin
      @(posedge sys_clk);
      override_active <= ovr;
      rx_data_id <= 8'h09;
      wait_load;
      `CHK("prog", {4'h0, prog_number}, tx_area[47:40])
      `CHK("lock", ovr ? 8'h00 : 8'h01, tx_area[55:48])
      `CHK("seq09", 8'h01, tx_area[15:8])
      `CHK("len09", 16'h0002, {tx_area[23:16], tx_area[31:24]})
      go_idle;
    end
  endtask
  task automatic t_none;
    reg [39:0] idl;
    integer    k, hits;
    begin
      idl = 40'hff_90_80_10_00;
      hits = 0;
      for (k = 0; k < 5; k++) begin
        @(posedge sys_clk);
        rx_data_id <= idl[8 * k +: 8];
        pulse_trigger;
        repeat (40) begin
          @(negedge sys_clk);
          if (packet_loaded === 1'b1) hits++;
        end
      end
      `CHK("quiet", 0, hits)
      go_idle;
    end
  endtask
  task automatic run_sel(input [7:0] id);
    integer p, k, j;
    begin
      @(posedge sys_clk);
      rx_data_id <= id;
      repeat (4) @(posedge sys_clk);
      build(id);
      pulse_trigger;
      k = 0;
      for (p = 1; k < en || p == 1; p++) begin
        wait_load;
        `CHK("seq", p[7:0], tx_area[15:8])
        `CHK("len", en[15:0], {tx_area[23:16], tx_area[31:24]})
        `CHK("id", id, tx_area[39:32])
        for (j = 5; j < 32; j++) begin
          `CHK("user", (k < en) ? eb[k] : 8'h00, tx_area[8 * j +: 8])
          k++;
        end
      end
      npk = p - 1;
      extra = 0;
      // No packet may follow the last acknowledged one
      repeat (40) begin
        @(negedge sys_clk);
        if (packet_loaded === 1'b1) extra++;
      end
      `CHK("extra", 0, extra)
      go_idle;
    end
  endtask
  // ==========================================================
  // Clock, watchdog, main sequence
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #(8 * 30000);
    bad_count++;
    stop_test;
  end
  initial begin
    bad_count = 0;
    n_checks = 0;
    rst = 1'b1;
    rx_data_id = 8'h00;
    control_lock = 1'b1;
    processing_trigger = 1'b0;
    override_active = 1'b0;
    quality_max_level = 1'b1;
    verify_job_on = 1'b1;
    swap_bytes = 1'b0;
    result_valid = 1'b1;
    ack_slow = 1'b0;
    prog_number = 4'ha;
    str_len = 8'h03;
    pos = 64'h1234_fedc_0102_8001;
    qual_abs = 128'h40490fdb_3f800000_bf000000_41200000;
    qual_cls = 40'h45_44_43_42_41;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_prog(1'b0);
    t_prog(1'b1);
    t_none;
    for (i = 8'h81; i <= 8'h8f; i++) begin
      swap_bytes <= i[0];
      ack_slow <= i[1];
      run_sel(i[7:0]);
    end
    // Reduced quality level and no verification job
    quality_max_level <= 1'b0;
    verify_job_on <= 1'b0;
    run_sel(8'h8f);
    // Long string spans two packets, slow acks
    t_fifo;
    stop_test;
  end
endmodule // rrds_top_test
